// File: logic/smw_sensor_mode_and_wake_timer.v
// Behaviour
// R1: Slow oscillator, 14 stages, wake every 16384
// R2: Ten more stages give rare host reset
// R3: Compare sample against 8-bit threshold on output
// R4: Host steps threshold to detect or convert
// R5: Two mode pins decode four modes
// R6: Low pin only: pressure path on, routed
// R7: Low pin falls: mux opens before powerdown
// R8: High pin only: temperature path on, routed
// R9: High pin falls: mux opens before powerdown
// R10: Mux, threshold, oscillator, dividers always powered
// R11: Trim bits always powered
// R12: Overvoltage on high pin enters trim/test
// R13: Host drives inputs low without supply
// R14: Bit counter reset in measure modes
// R15: Sample rising MSB first, latch eighth fall
// R16: Standby output high, low on wake overflow
// R17: Host reset low two cycles per overflow
// R18: Comparator enabled in read mode, synced decode
`timescale 1ns/1ns
`include "smw_defines.vh"

module smw_sensor_mode_and_wake_timer
#(
	parameter OSC_DIV      = `SMW_OSC_DIV,
	parameter WAKE_STAGES  = `SMW_WAKE_STAGES,
	parameter CHAIN_STAGES = `SMW_CHAIN_STAGES,
	parameter THR_BITS     = `SMW_THR_BITS
)
(
	input  wire                core_clk,
	input  wire                resetn,
	input  wire                modeSelLo,
	input  wire                modeSelHi,
	input  wire                trimOverVolt,
	input  wire                serialData,
	input  wire                shiftClk,
	input  wire                compareIn,
	output reg                 compareWake,
	output reg                 hostResetn,
	output reg                 pressurePowerOn,
	output reg                 pressureMuxOn,
	output reg                 tempPowerOn,
	output reg                 tempMuxOn,
	output reg                 comparatorOn,
	output reg                 alwaysOnPower,
	output reg                 trimPowerOn,
	output reg                 trimTestMode,
	output reg  [THR_BITS-1:0] threshold
);
	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	wire [5:0] pinSync;

	smw_sync #(.W(6)) smw_sync_inst
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.pinIn    ({trimOverVolt, compareIn, shiftClk, serialData, modeSelHi, modeSelLo}),
		.pinSync  (pinSync)
	);

	wire       loS   = pinSync[0];
	wire       hiS   = pinSync[1];
	wire       datS  = pinSync[2];
	wire       clkS  = pinSync[3];
	wire       cmpS  = pinSync[4];
	wire       trimS = pinSync[5];
	wire [1:0] mode  = {hiS, loS}; // R18 R5

	// ------------------------------------------------------------
	// Mode decode and path sequencing
	// ------------------------------------------------------------
	// Mode states, one-hot
	localparam [4:0] ST_STANDBY  = 5'h01;
	localparam [4:0] ST_PRESSURE = 5'h02;
	localparam [4:0] ST_TEMP     = 5'h04;
	localparam [4:0] ST_READ     = 5'h08;
	localparam [4:0] ST_TRIM     = 5'h10;

	reg [4:0] state;
	reg [4:0] next_state;

	always @*
	begin
		if (trimS)
			next_state = ST_TRIM; // R12
		else
		begin
			case (mode) // R5
				`SMW_MODE_PRESSURE: next_state = ST_PRESSURE;
				`SMW_MODE_TEMP:     next_state = ST_TEMP;
				`SMW_MODE_READ:     next_state = ST_READ;
				default:            next_state = ST_STANDBY;
			endcase
		end
	end

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state <= ST_STANDBY;
		else
			state <= next_state;
	end

	// Power follows the mode and the mux closes a cycle later; power drops one cycle after the mux,
	// so the held sample is isolated before its source collapses.
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pressureMuxOn   <= 1'b0;
			pressurePowerOn <= 1'b0;
			tempMuxOn       <= 1'b0;
			tempPowerOn     <= 1'b0;
			comparatorOn    <= 1'b0;
			trimTestMode    <= 1'b0;
			alwaysOnPower   <= 1'b0;
			trimPowerOn     <= 1'b0;
		end
		else
		begin
			pressureMuxOn   <= (next_state == ST_PRESSURE) && pressurePowerOn; // R6
			pressurePowerOn <= (next_state == ST_PRESSURE) || pressureMuxOn; // R6 R7
			tempMuxOn       <= (next_state == ST_TEMP) && tempPowerOn; // R8
			tempPowerOn     <= (next_state == ST_TEMP) || tempMuxOn; // R8 R9
			comparatorOn    <= (next_state == ST_READ); // R18
			trimTestMode    <= (next_state == ST_TRIM); // R12
			alwaysOnPower   <= 1'b1; // R10
			trimPowerOn     <= 1'b1; // R11
		end
	end

	// ------------------------------------------------------------
	// Serial threshold shifter
	// ------------------------------------------------------------
	reg                      clkPrev;
	reg [THR_BITS-1:0]       shiftReg;
	reg [`SMW_BITCNT_W-1:0]  bitCnt;
	reg                      eighthSeen;
	wire measuring = (state == ST_PRESSURE) || (state == ST_TEMP);
	wire clkRise   = clkS && !clkPrev;
	wire clkFall   = !clkS && clkPrev;

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clkPrev    <= 1'b0;
			shiftReg   <= `SMW_THR_RESET;
			bitCnt     <= {`SMW_BITCNT_W{1'b0}};
			eighthSeen <= 1'b0;
			threshold  <= `SMW_THR_RESET;
		end
		else
		begin
			clkPrev <= clkS;
			if (measuring)
			begin
				bitCnt     <= {`SMW_BITCNT_W{1'b0}}; // R14
				eighthSeen <= 1'b0;
			end
			else if (clkRise)
			begin
				shiftReg   <= {shiftReg[THR_BITS-2:0], datS}; // R15
				eighthSeen <= (bitCnt == {`SMW_BITCNT_W{1'b1}});
				bitCnt     <= bitCnt + 1'b1;
			end
			else if (clkFall && eighthSeen)
			begin
				threshold  <= shiftReg; // R15
				eighthSeen <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Slow oscillator and divider chain
	// ------------------------------------------------------------
	// Oscillator is modelled as a tick every OSC_DIV core cycles.
	reg [15:0]             oscCnt;
	reg [CHAIN_STAGES-1:0] chain;
	reg [1:0]              rstLowCnt;
	reg                    wakeLow;
	wire oscTick = (oscCnt == OSC_DIV[15:0] - 16'h0001);
	wire wakeOvf = oscTick && (&chain[WAKE_STAGES-1:0]); // R1
	wire fullOvf = oscTick && (&chain); // R2

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			oscCnt    <= 16'h0000;
			chain     <= {CHAIN_STAGES{1'b0}};
			rstLowCnt <= 2'h0;
			wakeLow   <= 1'b0;
		end
		else
		begin
			oscCnt <= oscTick ? 16'h0000 : oscCnt + 16'h0001; // R10
			if (oscTick)
			begin
				chain <= chain + 1'b1; // R1 R2
				wakeLow <= wakeOvf; // R16
				if (fullOvf)
					rstLowCnt <= `SMW_RST_LOW_CYC; // R17
				else if (rstLowCnt != 2'h0)
					rstLowCnt <= rstLowCnt - 2'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Output pins
	// ------------------------------------------------------------
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			compareWake <= 1'b1;
			hostResetn  <= 1'b1;
		end
		else
		begin
			hostResetn <= (rstLowCnt == 2'h0); // R17
			// Decoded from next_state so the pin and comparatorOn switch together
			if (next_state == ST_READ)
				compareWake <= cmpS; // R3 R18
			else if (next_state == ST_STANDBY)
				compareWake <= !wakeLow; // R16
			else
				compareWake <= 1'b1;
		end
	end
endmodule

// File: logic/smw_defines.vh
`ifndef SMW_DEFINES_VH
`define SMW_DEFINES_VH

// Mode encodings {hi, lo}
`define SMW_MODE_STANDBY   2'h0
`define SMW_MODE_PRESSURE  2'h1
`define SMW_MODE_TEMP      2'h2
`define SMW_MODE_READ      2'h3

// Divider chain
`define SMW_WAKE_STAGES    14
`define SMW_EXTRA_STAGES   10
`define SMW_CHAIN_STAGES   24
`define SMW_RST_LOW_CYC    2'h2

// Serial threshold
`define SMW_THR_BITS       8
`define SMW_THR_RESET      8'h00
`define SMW_BITCNT_W       3

// Slow oscillator as a divide of core_clk (25 MHz / 5.4 kHz)
`define SMW_CORE_HZ        25000000
`define SMW_OSC_HZ         5400
`define SMW_OSC_DIV        (`SMW_CORE_HZ / `SMW_OSC_HZ)

`endif

// File: logic/smw_sync.v
`timescale 1ns/1ns
`include "smw_defines.vh"

// Two-flop synchroniser for a group of pin inputs
module smw_sync
#(
	parameter W = 4
)
(
	input  wire         core_clk,
	input  wire         resetn,
	input  wire [W-1:0] pinIn,
	output reg  [W-1:0] pinSync
);
	reg [W-1:0] meta;

	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta    <= {W{1'b0}};
			pinSync <= {W{1'b0}};
		end
		else
		begin
			meta    <= pinIn;
			pinSync <= meta;
		end
	end
endmodule

// File: dv/smw_properties.sv
`timescale 1ns/1ns
module smw_properties
(
	input wire core_clk,
	input wire resetn,
	input wire modeSelLo,
	input wire modeSelHi,
	input wire trimOverVolt,
	input wire compareWake,
	input wire hostResetn,
	input wire pressurePowerOn,
	input wire pressureMuxOn,
	input wire tempPowerOn,
	input wire tempMuxOn,
	input wire comparatorOn,
	input wire alwaysOnPower,
	input wire trimPowerOn,
	input wire trimTestMode
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// --------
	// Counts assume OSC_DIV of 4 in the bench
	// --------
	pressSeq_a: assert property (pressureMuxOn || $fell(pressureMuxOn) |-> pressurePowerOn)
		else $error("pressure mux without power");
	tempSeq_a: assert property (tempMuxOn || $fell(tempMuxOn) |-> tempPowerOn)
		else $error("temp mux without power");
	pressMode_a: assert property ((modeSelLo && !modeSelHi && !trimOverVolt) [*5]
		|-> pressurePowerOn && !tempPowerOn && !comparatorOn) else $error("pressure decode");
	tempMode_a: assert property ((!modeSelLo && modeSelHi && !trimOverVolt) [*5]
		|-> tempPowerOn && !pressurePowerOn && !comparatorOn) else $error("temp decode");
	readMode_a: assert property ((modeSelLo && modeSelHi && !trimOverVolt) [*5]
		|-> comparatorOn && !pressurePowerOn && !tempPowerOn) else $error("read decode");
	trimMode_a: assert property (trimOverVolt [*5] |-> trimTestMode && !comparatorOn)
		else $error("trim mode missed");
	alwaysOn_a: assert property ($past(resetn) |-> alwaysOnPower && trimPowerOn)
		else $error("always-on supply dropped");
	hostPulse_a: assert property ($fell(hostResetn) |-> !hostResetn [*8] ##1 hostResetn)
		else $error("host reset width");
	wakeWidth_a: assert property ((!compareWake && !comparatorOn) [*4] ##1 !comparatorOn
		|-> compareWake) else $error("wake pulse too long");
endmodule

// File: dv/smw_host.sv
`timescale 1ns/1ns
module smw_host
(
	input wire core_clk
);
	// Idle lines rest low, as the pin pull-downs leave them
	logic shiftClk   = 1'b0;
	logic serialData = 1'b0;
	// --------
	// Frame of n bits, 320 ns clock that stands still outside it
	// --------
	task sendByte(input logic [7:0] b, input int n);
		for (int i = 7; i > 7 - n; i--)
		begin
			serialData <= b[i];
			repeat (4) @(posedge core_clk);
			shiftClk <= 1'b1;
			repeat (4) @(posedge core_clk);
			shiftClk <= 1'b0;
		end
		repeat (4) @(posedge core_clk);
		serialData <= 1'b0;
	endtask
endmodule

// File: dv/test_sensor_mode_and_wake_timer.sv
`timescale 1ns/1ns
module test_sensor_mode_and_wake_timer;
	logic       core_clk;
	logic       resetn;
	logic       modeSelLo;
	logic       modeSelHi;
	logic       trimOverVolt;
	logic       compareIn;
	logic       compareWake;
	logic       hostResetn;
	logic [7:0] threshold;
	logic [7:0] lastThr;
	logic [7:0] prevExp;
	logic [7:0] expT;
	logic [7:0] b;
	logic [7:0] expQ[$];
	int         seed;
	int         miscompares;
	int         samplesChecked;
	int         k;
	localparam int OSC = 4;

	smw_host smw_host_inst (.core_clk(core_clk));
	smw_sensor_mode_and_wake_timer #(.OSC_DIV(OSC), .WAKE_STAGES(4), .CHAIN_STAGES(6))
	smw_sensor_mode_and_wake_timer_inst
	(
		.core_clk(core_clk), .resetn(resetn), .modeSelLo(modeSelLo), .modeSelHi(modeSelHi),
		.trimOverVolt(trimOverVolt), .serialData(smw_host_inst.serialData),
		.shiftClk(smw_host_inst.shiftClk), .compareIn(compareIn), .compareWake(compareWake),
		.hostResetn(hostResetn), .pressurePowerOn(), .pressureMuxOn(), .tempPowerOn(),
		.tempMuxOn(), .comparatorOn(), .alwaysOnPower(), .trimPowerOn(), .trimTestMode(),
		.threshold(threshold)
	);

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samplesChecked++;
		if (e !== g)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask

	task results;
		$display("compares %0d mismatches %0d", samplesChecked, miscompares);
		if (miscompares == 0 && samplesChecked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task setMode(input logic [1:0] m, input logic t, input int n);
		@(posedge core_clk);
		{modeSelHi, modeSelLo} <= m;
		trimOverVolt <= t;
		compareIn <= 1'($random(seed));
		repeat (n) @(posedge core_clk);
	endtask

	// Distinct from the last byte so every load shows as a change
	task sendFull;
		b = 8'($random(seed));
		if (b === prevExp)
			b = ~b;
		prevExp = b;
		expQ.push_back(b);
		smw_host_inst.sendByte(b, 8);
		repeat (8) @(posedge core_clk);
	endtask

	// Skips a pulse already under way, then measures the next one whole
	task waitLow(input logic hr, input int w);
		int j;
		int n;
		for (j = 0; j < 20 && (hr ? hostResetn : compareWake) !== 1'b1; j++)
			@(posedge core_clk);
		for (j = 0; j < 300 && (hr ? hostResetn : compareWake) !== 1'b0; j++)
			@(posedge core_clk);
		for (n = 0; n < 20 && (hr ? hostResetn : compareWake) === 1'b0; n++)
			@(posedge core_clk);
		if (j == 300)
		begin
			miscompares++;
			results;
		end
		else
			chk(hr ? "hostWidth" : "wakeWidth", 8'(w), 8'(n));
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// --------
	// Threshold watcher
	// --------
	always @(posedge core_clk)
		if (resetn && threshold !== lastThr)
		begin
			expT = expQ.size() ? expQ.pop_front() : lastThr;
			chk("threshold", expT, threshold);
			lastThr = threshold;
		end

	initial
	begin
		seed = 32'hB705F693;
		{resetn, modeSelLo, modeSelHi, trimOverVolt, compareIn} = 5'h00;
		lastThr = 8'h00;
		prevExp = 8'h00;
		repeat (5) @(posedge core_clk);
		resetn <= 1'b1;
		sendFull;
		smw_host_inst.sendByte(8'hA5, 3);
		setMode(2'h1, 1'b0, 12);
		setMode(2'h0, 1'b0, 4);
		sendFull;
		setMode(2'h2, 1'b0, 4);
		smw_host_inst.sendByte(8'h5A, 8);
		setMode(2'h3, 1'b0, 4);
		sendFull;
		for (k = 0; k < 8; k++)
			setMode(k[1:0], k[2], 8);
		for (k = 0; k < 8; k++)
		begin
			setMode(2'h3, 1'b0, 8);
			chk("compareWake", {7'h00, compareIn}, {7'h00, compareWake});
		end
		setMode(2'h0, 1'b0, 4);
		waitLow(1'b0, OSC);
		waitLow(1'b1, 2 * OSC);
		chk("pending", 8'h00, 8'(expQ.size()));
		results;
	end
endmodule

bind smw_sensor_mode_and_wake_timer smw_properties smw_properties_inst
(
	.core_clk        (core_clk),
	.resetn          (resetn),
	.modeSelLo       (modeSelLo),
	.modeSelHi       (modeSelHi),
	.trimOverVolt    (trimOverVolt),
	.compareWake     (compareWake),
	.hostResetn      (hostResetn),
	.pressurePowerOn (pressurePowerOn),
	.pressureMuxOn   (pressureMuxOn),
	.tempPowerOn     (tempPowerOn),
	.tempMuxOn       (tempMuxOn),
	.comparatorOn    (comparatorOn),
	.alwaysOnPower   (alwaysOnPower),
	.trimPowerOn     (trimPowerOn),
	.trimTestMode    (trimTestMode)
);
